// ===== hdl/itl_defines.svh
// register offsets, field positions, reset values and timing counts
`ifndef ITL_DEFINES_SVH
`define ITL_DEFINES_SVH

// -----------------------------------------------------------------------------
// register byte offsets
// -----------------------------------------------------------------------------
`define ITL_OFF_STATUS 12'h000
`define ITL_OFF_MASK 12'h004
`define ITL_OFF_OUTPORT 12'h008
`define ITL_OFF_TCTRL 12'h00C
`define ITL_OFF_TLOAD0 12'h010
`define ITL_OFF_TLOAD1 12'h014
`define ITL_OFF_TCNT0 12'h018
`define ITL_OFF_TCNT1 12'h01C
`define ITL_OFF_CFG 12'h020
`define ITL_OFF_SRC 12'h024
`define ITL_OFF_LEVELS 12'h028

// -----------------------------------------------------------------------------
// status and mask bit positions
// -----------------------------------------------------------------------------
`define ITL_ST_TMR0 0
`define ITL_ST_TMR1 1
`define ITL_ST_LVL4 2
`define ITL_ST_LVL5 3
`define ITL_ST_LVL8 4
`define ITL_ST_W 5

// -----------------------------------------------------------------------------
// source vector bit positions
// -----------------------------------------------------------------------------
`define ITL_SRC_VME 0
`define ITL_SRC_SCSI 1
`define ITL_SRC_ENET 2
`define ITL_SRC_PAR 3
`define ITL_SRC_SER 4
`define ITL_SRC_PFAIL 5
`define ITL_SRC_DSP 6
`define ITL_SRC_VRET 7
`define ITL_SRC_ADDR 8
`define ITL_SRC_PERR 9
`define ITL_SRC_FPU 10
`define ITL_SRC_W 11

// -----------------------------------------------------------------------------
// reset values and counts
// -----------------------------------------------------------------------------
`define ITL_OUTPORT_RST 8'h00
`define ITL_OUTPORT_MASK 8'h1F
`define ITL_CFG_RST 6'h00
`define ITL_TLOAD_RST 16'h03E8
`define ITL_DIV_RATIO 4'hA
`define ITL_BOOT_CYCLES 3'h4
`define ITL_RESP_OKAY 2'h0
`define ITL_RESP_SLVERR 2'h2

`endif

// ===== hdl/itl_pkg.sv
// types shared by the interrupt and timer logic
package itl_pkg;
    typedef struct packed {
        logic       istream;
        logic       pstore;
        logic [1:0] drefill;
        logic [1:0] irefill;
    } itl_cfg_t;

    typedef enum logic [1:0] {
        ITL_BOOT_IDLE,
        ITL_BOOT_DRIVE,
        ITL_BOOT_RUN
    } itl_boot_t;
endpackage : itl_pkg

// ===== hdl/itl_top.sv
// interrupt routing, microsecond timer, boot pattern and output port
//
// Contract
// - drive boot pattern during last four reset cycles
// - boot pattern encodes cache refill and feature bits
// - divide external 10 MHz clock by ten
// - software interval timers raise interrupt on expiry
// - six interrupt request wires are levels
// - lowest three levels never driven by hardware
// - level three FPU; level four VME and I/O
// - level five power fail, DSP, retrace
// - levels six, seven timers; eight errors
// - interrupt requests also sent to DSP
// - registers readable, including timer state
// - 8-bit output port, top three reserved
// - four port bits drive status LEDs
//
// The placing of the registers and the AXI4-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "itl_defines.svh"

module itl_top (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // processor reset sequence (high while the core is held in reset)
    input wire logic cpu_reset,
    // external 10 MHz timebase, sampled as a level
    input wire logic ext_clk10,
    // interrupt sources, levels
    input wire logic [10:0] src_irq,
    // processor and dsp interrupt lines
    output logic [5:0] cpu_int,
    output logic [5:0] dsp_int,
    output logic irq,
    // output port and leds
    output logic [7:0] out_port,
    output logic [3:0] led,
    // axi4-lite write address
    input wire logic [11:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // axi4-lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // axi4-lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // axi4-lite read
    input wire logic [11:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);

    // -------------------------------------------------------------------------
    // address decode
    // -------------------------------------------------------------------------
    function automatic logic is_mapped(input logic [11:0] a);
        case (a)
            `ITL_OFF_STATUS, `ITL_OFF_MASK, `ITL_OFF_OUTPORT, `ITL_OFF_TCTRL,
            `ITL_OFF_TLOAD0, `ITL_OFF_TLOAD1, `ITL_OFF_TCNT0, `ITL_OFF_TCNT1,
            `ITL_OFF_CFG, `ITL_OFF_SRC, `ITL_OFF_LEVELS: is_mapped = 1'b1;
            default: is_mapped = 1'b0;
        endcase
    endfunction : is_mapped

    logic [11:0] awaddr_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic aw_have_r;
    logic w_have_r;
    logic [`ITL_ST_W-1:0] status_r;
    logic [`ITL_ST_W-1:0] mask_r;
    logic [7:0] port_r;
    logic [1:0] ten_r;
    logic [1:0] tmr_auto_r;
    logic [15:0] tload_r [2];
    logic [15:0] tcnt_r [2];
    itl_pkg::itl_cfg_t cfg_r;
    itl_pkg::itl_boot_t boot_r;
    logic [2:0] boot_cnt_r;

    wire wr_fire = aw_have_r && w_have_r && !s_axi_bvalid;
    wire wr_ok = wr_fire && is_mapped(awaddr_r);
    wire wr_lane0 = wr_ok && wstrb_r[0];
    wire wr_lanes01 = wr_ok && (wstrb_r[1:0] == 2'h3);
    wire rd_fire = s_axi_arvalid && s_axi_arready;

    // -------------------------------------------------------------------------
    // microsecond tick from the 10 MHz input
    // -------------------------------------------------------------------------
    // the input is taken as synchronous; only rising edges count
    logic clk10_d_r;
    logic [3:0] div_r;
    wire clk10_rise = ext_clk10 && !clk10_d_r;
    wire div_wrap = clk10_rise && (div_r == `ITL_DIV_RATIO - 4'h1);
    wire [3:0] div_nxt = !clk10_rise ? div_r : (div_wrap ? 4'h0 : div_r + 4'h1);
    logic us_tick_r;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clk10_d_r <= 1'b0;
            div_r <= 4'h0;
            us_tick_r <= 1'b0;
        end else begin
            clk10_d_r <= ext_clk10;
            div_r <= div_nxt;
            us_tick_r <= div_wrap;
        end
    end

    // -------------------------------------------------------------------------
    // interval timers
    // -------------------------------------------------------------------------
    logic [1:0] tmr_expire;
    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_tmr
            // a load of zero would never expire; count it as one
            wire at_end = (tcnt_r[gi] <= 16'h0001);
            assign tmr_expire[gi] = ten_r[gi] && us_tick_r && at_end;
            wire load_wr = wr_lanes01 &&
                (awaddr_r == (gi == 0 ? `ITL_OFF_TLOAD0 : `ITL_OFF_TLOAD1));
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    tload_r[gi] <= `ITL_TLOAD_RST;
                    tcnt_r[gi] <= `ITL_TLOAD_RST;
                end else begin
                    if (load_wr) begin
                        tload_r[gi] <= wdata_r[15:0];
                        tcnt_r[gi] <= wdata_r[15:0];
                    end else if (tmr_expire[gi]) begin
                        tcnt_r[gi] <= tload_r[gi];
                    end else if (ten_r[gi] && us_tick_r) begin
                        tcnt_r[gi] <= tcnt_r[gi] - 16'h0001;
                    end
                end
            end
        end
    endgenerate

    // one-shot timers drop their enable after expiring
    wire [1:0] ten_nxt = (wr_lane0 && awaddr_r == `ITL_OFF_TCTRL) ? wdata_r[1:0] :
                         (ten_r & ~(tmr_expire & ~tmr_auto_r));

    // -------------------------------------------------------------------------
    // interrupt level mapping
    // -------------------------------------------------------------------------
    // levels are pure or-trees of source levels, so a level holds while any
    // of its sources is still asserted
    wire lvl3 = src_irq[`ITL_SRC_FPU];
    wire lvl4 = |src_irq[`ITL_SRC_SER:`ITL_SRC_VME];
    wire lvl5 = |src_irq[`ITL_SRC_VRET:`ITL_SRC_PFAIL];
    wire lvl8 = src_irq[`ITL_SRC_ADDR] | src_irq[`ITL_SRC_PERR];

    wire [`ITL_ST_W-1:0] events = {lvl8, lvl5, lvl4, tmr_expire};
    // set wins over a same-cycle write-one clear
    wire st_clr = wr_lane0 && (awaddr_r == `ITL_OFF_STATUS);
    wire [`ITL_ST_W-1:0] status_nxt =
        (status_r & ~(st_clr ? wdata_r[`ITL_ST_W-1:0] : {`ITL_ST_W{1'b0}})) | events;

    // timer levels follow the sticky bits, so they stay up until cleared
    wire [5:0] run_lines = {lvl8, status_r[`ITL_ST_TMR1], status_r[`ITL_ST_TMR0],
                            lvl5, lvl4, lvl3};

    // -------------------------------------------------------------------------
    // reset-time mode pattern
    // -------------------------------------------------------------------------
    // the count of reset cycles left is unknown here, so the pattern is held
    // for the whole sequence; the core samples it in its last four cycles
    wire [5:0] boot_pattern = cfg_r;
    wire boot_drive = (boot_r != itl_pkg::ITL_BOOT_RUN);
    wire [5:0] lines_nxt = boot_drive ? boot_pattern : run_lines;
    itl_pkg::itl_boot_t boot_nxt;
    always_comb begin
        boot_nxt = boot_r;
        case (boot_r)
            itl_pkg::ITL_BOOT_IDLE:
                if (cpu_reset) boot_nxt = itl_pkg::ITL_BOOT_DRIVE;
            itl_pkg::ITL_BOOT_DRIVE:
                if (!cpu_reset && boot_cnt_r == `ITL_BOOT_CYCLES)
                    boot_nxt = itl_pkg::ITL_BOOT_RUN;
            itl_pkg::ITL_BOOT_RUN:
                if (cpu_reset) boot_nxt = itl_pkg::ITL_BOOT_DRIVE;
            default: boot_nxt = itl_pkg::ITL_BOOT_IDLE;
        endcase
    end
    // keep driving five cycles past reset release as margin
    wire [2:0] boot_cnt_nxt = cpu_reset ? 3'h0 :
        ((boot_r == itl_pkg::ITL_BOOT_DRIVE && boot_cnt_r != `ITL_BOOT_CYCLES) ?
         boot_cnt_r + 3'h1 : boot_cnt_r);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            boot_r <= itl_pkg::ITL_BOOT_IDLE;
            boot_cnt_r <= 3'h0;
            cpu_int <= 6'h00;
            dsp_int <= 6'h00;
        end else begin
            boot_r <= boot_nxt;
            boot_cnt_r <= boot_cnt_nxt;
            cpu_int <= lines_nxt;
            dsp_int <= run_lines;
        end
    end

    // -------------------------------------------------------------------------
    // control registers
    // -------------------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_r <= '0;
            mask_r <= '0;
            port_r <= `ITL_OUTPORT_RST;
            ten_r <= 2'h0;
            tmr_auto_r <= 2'h0;
            cfg_r <= `ITL_CFG_RST;
            irq <= 1'b0;
            out_port <= `ITL_OUTPORT_RST;
            led <= 4'h0;
        end else begin
            status_r <= status_nxt;
            ten_r <= ten_nxt;
            if (wr_lane0 && awaddr_r == `ITL_OFF_MASK)
                mask_r <= wdata_r[`ITL_ST_W-1:0];
            if (wr_lane0 && awaddr_r == `ITL_OFF_OUTPORT)
                port_r <= wdata_r[7:0] & `ITL_OUTPORT_MASK;
            if (wr_lane0 && awaddr_r == `ITL_OFF_TCTRL)
                tmr_auto_r <= wdata_r[5:4];
            if (wr_lane0 && awaddr_r == `ITL_OFF_CFG)
                cfg_r <= wdata_r[5:0];
            irq <= |(status_nxt & mask_r);
            out_port <= port_r;
            led <= port_r[3:0];
        end
    end

    // -------------------------------------------------------------------------
    // axi4-lite slave
    // -------------------------------------------------------------------------
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = 32'h0000_0000;
        case (s_axi_araddr)
            `ITL_OFF_STATUS: rd_mux[`ITL_ST_W-1:0] = status_r;
            `ITL_OFF_MASK: rd_mux[`ITL_ST_W-1:0] = mask_r;
            `ITL_OFF_OUTPORT: rd_mux[7:0] = port_r;
            `ITL_OFF_TCTRL: rd_mux[5:0] = {tmr_auto_r, 2'h0, ten_r};
            `ITL_OFF_TLOAD0: rd_mux[15:0] = tload_r[0];
            `ITL_OFF_TLOAD1: rd_mux[15:0] = tload_r[1];
            `ITL_OFF_TCNT0: rd_mux[15:0] = tcnt_r[0];
            `ITL_OFF_TCNT1: rd_mux[15:0] = tcnt_r[1];
            `ITL_OFF_CFG: rd_mux[5:0] = cfg_r;
            `ITL_OFF_SRC: rd_mux[`ITL_SRC_W-1:0] = src_irq;
            `ITL_OFF_LEVELS: rd_mux[5:0] = cpu_int;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            awaddr_r <= 12'h000;
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `ITL_RESP_OKAY;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `ITL_RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_r && !s_axi_awready && !s_axi_bvalid;
            s_axi_wready <= !w_have_r && !s_axi_wready && !s_axi_bvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_have_r <= 1'b1;
                awaddr_r <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_have_r <= 1'b1;
                wdata_r <= s_axi_wdata;
                wstrb_r <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= is_mapped(awaddr_r) ? `ITL_RESP_OKAY : `ITL_RESP_SLVERR;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (rd_fire) begin
                s_axi_arready <= 1'b0;
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_mux;
                s_axi_rresp <= is_mapped(s_axi_araddr) ? `ITL_RESP_OKAY : `ITL_RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule : itl_top

// ===== tb/itl_periph.sv
// behavioural model of the timebase and the interrupting peripherals
`timescale 1ns/1ps
module itl_periph (
    // clock
    input wire logic aclk,
    // requests wanted by the bench
    input wire logic [10:0] want,
    // toward the block
    output logic ext_clk10,
    output logic [10:0] src_irq
);
    // -------------------------------------------------------------------------
    // oscillator and request levels
    // -------------------------------------------------------------------------
    // phase offset keeps the timebase unrelated to aclk
    initial begin
        ext_clk10 = 1'b0;
        #13;
        forever #50 ext_clk10 = ~ext_clk10;
    end
    // no source sits below level three; requests held until withdrawn
    always @(posedge aclk) src_irq <= want;
endmodule : itl_periph

// ===== tb/itl_top_monitor.sv
// concurrent checks on the interrupt and timer block ports
`timescale 1ns/1ps
module itl_top_monitor (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // boot and sources
    input wire logic cpu_reset,
    input wire logic [10:0] src_irq,
    // interrupt lines and port
    input wire logic [5:0] cpu_int,
    input wire logic [5:0] dsp_int,
    input wire logic [7:0] out_port,
    input wire logic [3:0] led,
    // bus answers
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // -------------------------------------------------------------------------
    // boot tracking
    // -------------------------------------------------------------------------
    logic seen_r;
    logic [3:0] low_cnt_r;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seen_r <= 1'b0;
            low_cnt_r <= 4'h0;
        end else begin
            if (cpu_reset) seen_r <= 1'b1;
            if (cpu_reset) low_cnt_r <= 4'h0;
            else if (low_cnt_r != 4'hF) low_cnt_r <= low_cnt_r + 4'h1;
        end
    end
    sequence s_boot_end;
        cpu_reset [*3] ##1 !cpu_reset;
    endsequence
    property p_map(logic lvl, logic cause);
        $past(aresetn) |-> lvl == $past(cause);
    endproperty
    // -------------------------------------------------------------------------
    // assertions
    // -------------------------------------------------------------------------
    a_boot_hold: assert property (s_boot_end |-> $stable(cpu_int) [*3])
        else $error("boot pattern dropped early");
    a_cpu_run: assert property (seen_r && !cpu_reset && low_cnt_r > 4'h7 |-> cpu_int == dsp_int)
        else $error("cpu lines differ from dsp lines");
    a_fpu_level: assert property (p_map(dsp_int[0], src_irq[10]))
        else $error("level three wrong");
    a_io_level: assert property (p_map(dsp_int[1], |src_irq[4:0]))
        else $error("level four wrong");
    a_pfail_level: assert property (p_map(dsp_int[2], |src_irq[7:5]))
        else $error("level five wrong");
    a_error_level: assert property (p_map(dsp_int[5], src_irq[9] | src_irq[8]))
        else $error("level eight wrong");
    a_port_rsvd: assert property (out_port[7:5] == 3'h0)
        else $error("reserved port bits set");
    a_led_mirror: assert property ($past(aresetn) && $stable(out_port) |-> led == out_port[3:0])
        else $error("leds differ from port");
    a_rd_one_beat: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
        else $error("read answer repeated");
    a_wr_one_beat: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
        else $error("write answer repeated");
endmodule : itl_top_monitor
bind itl_top itl_top_monitor itl_top_monitor_i (.aclk, .aresetn, .cpu_reset, .src_irq, .cpu_int,
    .dsp_int, .out_port, .led, .s_axi_bvalid, .s_axi_bready, .s_axi_rvalid, .s_axi_rready);

// ===== tb/itl_top_bench.sv
// self-checking bench for the interrupt and timer block
`timescale 1ns/1ps
`include "itl_defines.svh"
module itl_top_bench;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic cpu_reset = 1'b0;
    logic [10:0] want = 11'h000;
    logic ext_clk10;
    logic [10:0] src_irq;
    logic [5:0] cpu_int, dsp_int;
    logic irq;
    logic [7:0] out_port;
    logic [3:0] led;
    logic [11:0] awaddr = 12'h000, araddr = 12'h000;
    logic [31:0] wdata = 32'h0;
    logic [3:0] wstrb = 4'hF;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0;
    logic awready, wready, bvalid, arready, rvalid;
    logic [1:0] bresp, rresp, rsp;
    logic [31:0] rdata, rd_val, v;
    int fail_count = 0;
    int tests_run = 0;
    int seed = 9;
    int n;
    always #4 aclk = ~aclk;
    itl_periph itl_periph_i (.aclk(aclk), .want(want), .ext_clk10(ext_clk10), .src_irq(src_irq));
    itl_top itl_top_i (.aclk(aclk), .aresetn(aresetn), .cpu_reset(cpu_reset),
        .ext_clk10(ext_clk10), .src_irq(src_irq), .cpu_int(cpu_int), .dsp_int(dsp_int),
        .irq(irq), .out_port(out_port), .led(led), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(1'b1), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    // -------------------------------------------------------------------------
    // helpers
    // -------------------------------------------------------------------------
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        if (fail_count == 0 && tests_run > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask : conclude
    task automatic hang(input int k);
        if (k >= 60) begin
            fail_count++;
            conclude();
        end
    endtask : hang
    // ready and answers are read before this edge's updates land
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        int k;
        k = 0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            k++;
        end while (!bvalid && k < 60);
        rsp = bresp;
        hang(k);
    endtask : wr
    task automatic rd(input logic [11:0] a);
        int k;
        k = 0;
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            k++;
        end while (!rvalid && k < 60);
        rd_val = rdata;
        rsp = rresp;
        hang(k);
    endtask : rd
    function automatic logic [5:0] exp_lvl(input logic [10:0] s);
        return {s[9] | s[8], 2'b00, |s[7:5], |s[4:0], s[10]};
    endfunction : exp_lvl
    // -------------------------------------------------------------------------
    // scenarios
    // -------------------------------------------------------------------------
    initial begin
        repeat (100000) @(posedge aclk);
        fail_count++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        rd(`ITL_OFF_TLOAD0);
        chk(rd_val, {16'h0, `ITL_TLOAD_RST});
        rd(12'h100);
        chk({30'h0, rsp}, {30'h0, `ITL_RESP_SLVERR});
        wr(12'h100, 32'h1);
        chk({30'h0, rsp}, {30'h0, `ITL_RESP_SLVERR});
        for (int i = 0; i < 4; i++) begin
            v = $random(seed);
            wr(`ITL_OFF_OUTPORT, v);
            chk({30'h0, rsp}, {30'h0, `ITL_RESP_OKAY});
            rd(`ITL_OFF_OUTPORT);
            chk(rd_val, {24'h0, v[7:0] & 8'h1F});
            chk({24'h0, out_port}, {24'h0, v[7:0] & 8'h1F});
            chk({28'h0, led}, {28'h0, v[3:0]});
        end
        // a write without lane 0 must leave the port alone
        wstrb <= 4'h2;
        wr(`ITL_OFF_OUTPORT, 32'hFF);
        wstrb <= 4'hF;
        rd(`ITL_OFF_OUTPORT);
        chk(rd_val, {24'h0, v[7:0] & 8'h1F});
        v = $random(seed);
        wr(`ITL_OFF_CFG, v);
        rd(`ITL_OFF_CFG);
        chk(rd_val, {26'h0, v[5:0]});
        cpu_reset <= 1'b1;
        repeat (6) @(posedge aclk);
        chk({26'h0, cpu_int}, {26'h0, v[5:0]});
        chk({26'h0, dsp_int}, 32'h0);
        cpu_reset <= 1'b0;
        repeat (3) @(posedge aclk);
        chk({26'h0, cpu_int}, {26'h0, v[5:0]});
        repeat (6) @(posedge aclk);
        chk({26'h0, cpu_int}, 32'h0);
        // two shared sources first, then one released
        for (int i = 0; i < 24; i++) begin
            v = (i == 0) ? 32'h3 : (i == 1) ? 32'h2 : $random(seed);
            want <= v[10:0];
            repeat (3) @(posedge aclk);
            chk({26'h0, dsp_int}, {26'h0, exp_lvl(v[10:0])});
            chk({26'h0, cpu_int}, {26'h0, exp_lvl(v[10:0])});
            rd(`ITL_OFF_SRC);
            chk(rd_val, {21'h0, v[10:0]});
        end
        want <= 11'h000;
        repeat (3) @(posedge aclk);
        wr(`ITL_OFF_STATUS, 32'h1F);
        rd(`ITL_OFF_STATUS);
        chk(rd_val, 32'h0);
        wr(`ITL_OFF_MASK, 32'h4);
        want <= 11'h020;
        repeat (5) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        want <= 11'h001;
        repeat (5) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        want <= 11'h000;
        repeat (3) @(posedge aclk);
        rd(`ITL_OFF_STATUS);
        chk(rd_val, 32'h0C);
        wr(`ITL_OFF_STATUS, 32'h04);
        repeat (2) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
        // three ticks of 125 cycles, first tick phase unknown;
        // timer 1 reloads itself every two ticks
        wr(`ITL_OFF_TLOAD0, 32'h3);
        wr(`ITL_OFF_TLOAD1, 32'h2);
        wr(`ITL_OFF_TCTRL, 32'h23);
        n = 0;
        while (dsp_int[3] !== 1'b1 && n < 1000) begin
            @(posedge aclk);
            n++;
        end
        if (n >= 1000) hang(n);
        chk({31'h0, n >= 245 && n <= 400}, 32'h1);
        rd(`ITL_OFF_TCTRL);
        chk(rd_val, 32'h22);
        rd(`ITL_OFF_TCNT0);
        chk(rd_val, 32'h3);
        rd(`ITL_OFF_TCNT1);
        chk(rd_val, 32'h1);
        chk({31'h0, cpu_int[3]}, 32'h1);
        rd(`ITL_OFF_LEVELS);
        chk(rd_val, 32'h18);
        wr(`ITL_OFF_TCTRL, 32'h0);
        wr(`ITL_OFF_STATUS, 32'h3);
        repeat (3) @(posedge aclk);
        chk({26'h0, dsp_int}, 32'h0);
        conclude();
    end
endmodule : itl_top_bench
